// file: logic/smr_mode_regs.sv
`timescale 1ns/1ps
`include "smr_regs.svh"
// Behaviour
// [R1] Info reports init status, kind, no invalid-data
// [R2] Info bits 4:3 give calibration test result
// [R3] Test result updates after calibration completes
// [R4] Faulty result: factory trim, ignore calibration
// [R5] Result 11 only means resistor present
// [R6] Feature register at 01h field layout
// [R7] Burst length codes 4, 8, 16; code 16 is stored but every 16-beat burst is refused as illegal
// [R8] Burst type and wrap bit decode
// [R9] Write recovery codes 3 to 8 cycles
// [R10] Auto-precharge starts after write recovery count
// [R11] Controller rounds recovery time up
// [R12] Four-beat wrap and no-wrap orders
// [R13] Eight-beat sequential and interleaved orders
// [R14] Reserved bits read as zero
// [R15] Writes to info register do nothing
// [R16] Info register at address 00h
// [R17] Column bit zero forced to zero
// [R18] Memory kind bit reads zero
module smr_mode_regs
  import smr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       mrw_valid,
  input  wire logic       mrr_valid,
  input  wire logic [7:0] mr_addr,
  input  wire logic [7:0] mr_wdata,
  output logic      [7:0] mrr_data,
  output logic            mrr_data_valid,
  input  wire logic       init_complete,
  input  wire logic       cal_init_done,
  input  wire logic [1:0] cal_test_code,
  input  wire logic       cal_cmd_req,
  output logic            cal_cmd_grant,
  output logic            factory_trim,
  input  wire logic       burst_req,
  input  wire logic       burst_write,
  input  wire logic       burst_ap,
  input  wire smr_col_t   burst_start,
  output logic            burst_ready,
  output logic            burst_illegal,
  output smr_col_t        beat_col,
  output logic            beat_valid,
  output logic            precharge_start
);

  // ========================================================================
  // Registers
  logic [7:0] feature_r;
  logic       auto_init_r;
  logic [1:0] cal_result_r;
  smr_state_t state_r;
  smr_col_t   base_r;
  logic [3:0] beat_r;
  logic [3:0] wr_cnt_r;
  logic       ap_pend_r;

  // Decoded feature fields, calibration fault and info word
  logic [2:0] burst_length;
  logic       burst_type;
  logic       wrap_control;
  logic [2:0] write_recovery_cycles;
  logic [3:0] last_beat;
  logic [3:0] wr_cycles;
  logic       cal_fault;
  logic [7:0] info_value;

  assign burst_length          = feature_r[`SMR_FEAT_BL_MSB:`SMR_FEAT_BL_LSB]; // R6
  assign burst_type            = feature_r[`SMR_FEAT_BT_BIT];                  // R6
  assign wrap_control          = feature_r[`SMR_FEAT_WC_BIT];                  // R6
  assign write_recovery_cycles = feature_r[`SMR_FEAT_WR_MSB:`SMR_FEAT_WR_LSB]; // R6
  assign last_beat = (burst_length == `SMR_BL8) ? 4'h7 : 4'h3;                 // R7
  assign wr_cycles = {1'b0, write_recovery_cycles} + `SMR_WR_CODE_BIAS;        // R9

  // ========================================================================
  // Column for a given beat
  function automatic smr_col_t beat_address(input smr_col_t base, input logic [3:0] idx,
                                            input logic [2:0] bl, input logic bt,
                                            input logic wc);
    smr_col_t col;
    col = base;
    if (wc)
      col = base + {6'h00, idx};                                   // R12
    else if (bl == `SMR_BL8)
      col[2:0] = bt ? (base[2:0] ^ idx[2:0]) : (base[2:0] + idx[2:0]); // R13
    else
      col[1:0] = base[1:0] + idx[1:0];                             // R12
    return col;
  endfunction

  // Legal code checks for a feature write
  function automatic logic feature_legal(input logic [7:0] v);
    logic [2:0] bl;
    logic [2:0] wr;
    bl = v[`SMR_FEAT_BL_MSB:`SMR_FEAT_BL_LSB];
    wr = v[`SMR_FEAT_WR_MSB:`SMR_FEAT_WR_LSB];
    return (bl == `SMR_BL4 || bl == `SMR_BL8 || bl == `SMR_BL16) &&
           (wr >= `SMR_WR_MIN_CODE) && (wr <= `SMR_WR_MAX_CODE);
  endfunction

  // ========================================================================
  // Feature register write; info address writes fall through
  always_ff @(posedge clk)
  begin
    if (srst)
      feature_r <= `SMR_FEAT_RESET;                                // R8
    else if (mrw_valid && mr_addr == `SMR_ADDR_FEATURE && feature_legal(mr_wdata))
      feature_r <= mr_wdata;                                       // R7 R9 R15
  end

  // Auto-initialisation status
  always_ff @(posedge clk)
  begin
    if (srst)
      auto_init_r <= 1'b1;
    else if (init_complete)
      auto_init_r <= 1'b0;                                         // R1
  end

  // Calibration self-test result, taken at calibration completion
  always_ff @(posedge clk)
  begin
    if (srst)
      cal_result_r <= `SMR_CAL_NONE;
    else if (cal_init_done)
      cal_result_r <= cal_test_code;                               // R3 R5
  end

  assign cal_fault = (cal_result_r == `SMR_CAL_SUPPLY) ||
                     (cal_result_r == `SMR_CAL_GROUND);            // R4
  assign factory_trim  = cal_fault;                                // R4
  assign cal_cmd_grant = cal_cmd_req && !cal_fault;                // R4

  // Information word, reserved bits zero
  always_comb
  begin
    info_value = 8'h00;                                            // R14
    info_value[`SMR_INFO_AUTO_BIT] = auto_init_r;                  // R1
    info_value[`SMR_INFO_KIND_BIT] = 1'b0;                         // R18
    info_value[`SMR_INFO_DNV_BIT]  = 1'b0;                         // R1
    info_value[`SMR_INFO_CAL_LSB +: 2] = cal_result_r;             // R2
  end

  // ========================================================================
  // Mode register read answer, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mrr_data       <= 8'h00;
      mrr_data_valid <= 1'b0;
    end
    else
    begin
      mrr_data_valid <= mrr_valid;
      if (mrr_valid)
        mrr_data <= (mr_addr == `SMR_ADDR_INFO) ? info_value : 8'h00; // R16 R14
    end
  end

  // ========================================================================
  // Burst engine
  assign burst_ready = (state_r == SMR_IDLE);
  assign burst_illegal = burst_req && burst_ready &&
                         (wrap_control ? (burst_length != `SMR_BL4)
                                       : (burst_length == `SMR_BL16)); // R13

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r   <= SMR_IDLE;
      base_r    <= '0;
      beat_r    <= 4'h0;
      ap_pend_r <= 1'b0;
      wr_cnt_r  <= 4'h0;
    end
    else
    begin
      case (state_r)
        SMR_IDLE:
        begin
          if (burst_req && !burst_illegal)
          begin
            state_r   <= SMR_BURST;
            base_r    <= {burst_start[9:1], 1'b0};                 // R17
            beat_r    <= 4'h0;
            ap_pend_r <= burst_write && burst_ap;
          end
        end
        SMR_BURST:
        begin
          if (beat_r == last_beat)
          begin
            state_r  <= ap_pend_r ? SMR_RECOVER : SMR_IDLE;
            wr_cnt_r <= wr_cycles - 4'h1;                          // R10
          end
          beat_r <= beat_r + 4'h1;
        end
        SMR_RECOVER:
        begin
          if (wr_cnt_r == 4'h0)
            state_r <= SMR_IDLE;
          wr_cnt_r <= wr_cnt_r - 4'h1;
        end
        default:
          state_r <= SMR_IDLE;
      endcase
    end
  end

  // Beat address and precharge pulse outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      beat_col        <= '0;
      beat_valid      <= 1'b0;
      precharge_start <= 1'b0;
    end
    else
    begin
      beat_valid      <= (state_r == SMR_BURST);
      beat_col        <= beat_address(base_r, beat_r, burst_length, burst_type, wrap_control);
      precharge_start <= (state_r == SMR_RECOVER) && (wr_cnt_r == 4'h0); // R10
    end
  end

  // ========================================================================
  // Checks
  sequence last_beat_s;
    state_r == SMR_BURST && beat_r == last_beat && ap_pend_r;
  endsequence

  info_zero_a: assert property (@(posedge clk) disable iff (srst)
    mrr_valid && mr_addr == `SMR_ADDR_INFO |=> mrr_data_valid && mrr_data[7:5] == 3'h0 &&
    mrr_data[2:1] == 2'h0 && mrr_data[0] == $past(auto_init_r)) // R1
    else $error("info read wrong");
  cal_field_a: assert property (@(posedge clk) disable iff (srst)
    mrr_valid && mr_addr == `SMR_ADDR_INFO |=> mrr_data[4:3] == $past(cal_result_r)) // R2
    else $error("calibration field wrong");
  cal_hold_a: assert property (@(posedge clk) disable iff (srst)
    !cal_init_done |=> $stable(cal_result_r)) // R3
    else $error("calibration result moved");
  cal_block_a: assert property (@(posedge clk) disable iff (srst)
    cal_result_r inside {`SMR_CAL_SUPPLY, `SMR_CAL_GROUND} |->
    !cal_cmd_grant && factory_trim) // R4
    else $error("calibration not blocked");
  info_write_a: assert property (@(posedge clk) disable iff (srst)
    mrw_valid && mr_addr == `SMR_ADDR_INFO |=> $stable(feature_r)) // R15
    else $error("info write took effect");
  col_zero_a: assert property (@(posedge clk) disable iff (srst)
    beat_valid |-> beat_col[0] == $past(beat_r[0])) // R17
    else $error("column bit zero set");
  wrap_four_a: assert property (@(posedge clk) disable iff (srst)
    state_r == SMR_IDLE && burst_req && !burst_illegal && !wrap_control &&
    burst_length == `SMR_BL4 && burst_start[1] ##1 1'b1 |=> beat_col[1:0] == 2'h2 ##1
    beat_col[1:0] == 2'h3 ##1 beat_col[1:0] == 2'h0 ##1 beat_col[1:0] == 2'h1) // R12
    else $error("four beat wrap order wrong");
  eight_int_a: assert property (@(posedge clk) disable iff (srst)
    beat_valid && !wrap_control && burst_type && burst_length == `SMR_BL8 |->
    beat_col[2:0] == (base_r[2:0] ^ $past(beat_r[2:0]))) // R13
    else $error("interleaved order wrong");
  precharge_a: assert property (@(posedge clk) disable iff (srst)
    last_beat_s ##1 (wr_cnt_r == 4'h2) |-> ##3 precharge_start) // R10
    else $error("precharge late or early");
  feat_legal_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |-> (write_recovery_cycles >= `SMR_WR_MIN_CODE) &&
    (write_recovery_cycles <= `SMR_WR_MAX_CODE) && burst_length inside
    {`SMR_BL4, `SMR_BL8, `SMR_BL16}) // R7 R9
    else $error("reserved feature code stored");

endmodule // smr_mode_regs

// file: logic/smr_regs.svh
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH
// ==========================================================================
// Mode addresses
`define SMR_ADDR_INFO      8'h00
`define SMR_ADDR_FEATURE   8'h01
// ==========================================================================
// Feature register fields
`define SMR_FEAT_BL_LSB    0
`define SMR_FEAT_BL_MSB    2
`define SMR_FEAT_BT_BIT    3
`define SMR_FEAT_WC_BIT    4
`define SMR_FEAT_WR_LSB    5
`define SMR_FEAT_WR_MSB    7
`define SMR_FEAT_RESET     8'h22
// ==========================================================================
// Field codes
`define SMR_BL4            3'h2
`define SMR_BL8            3'h3
`define SMR_BL16           3'h4
`define SMR_WR_MIN_CODE    3'h1
`define SMR_WR_MAX_CODE    3'h6
`define SMR_WR_CODE_BIAS   4'h2
`define SMR_CAL_NONE       2'h0
`define SMR_CAL_SUPPLY     2'h1
`define SMR_CAL_GROUND     2'h2
`define SMR_CAL_OK         2'h3
// ==========================================================================
// Information register fields
`define SMR_INFO_AUTO_BIT  0
`define SMR_INFO_KIND_BIT  1
`define SMR_INFO_DNV_BIT   2
`define SMR_INFO_CAL_LSB   3
`endif

// file: logic/smr_pkg.sv
package smr_pkg;
  // ========================================================================
  // Burst engine states
  typedef enum logic [1:0] {SMR_IDLE, SMR_BURST, SMR_RECOVER} smr_state_t;
  typedef logic [9:0] smr_col_t;
endpackage

// file: dv/smr_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host model issuing mode register writes and reads
module smr_host
(
  input  wire logic       clk,
  output logic            mrw_valid,
  output logic            mrr_valid,
  output logic [7:0]      mr_addr,
  output logic [7:0]      mr_wdata
);
  initial {mrw_valid, mrr_valid, mr_addr, mr_wdata} = 18'h0;
  // Recovery code from a time in ns, rounded up to whole cycles
  function automatic logic [2:0] wr_code(input int twr_ns);
    return 3'((twr_ns + 24) / 25 - 2);
  endfunction
  // One strobe cycle, then both strobes drop and address and data show the inverse of their last value
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    {mrw_valid, mrr_valid, mr_addr, mr_wdata} = {w, !w, a, d};
    @(posedge clk);
    #2;
    {mrw_valid, mrr_valid, mr_addr, mr_wdata} = {2'h0, ~a, ~d};
  endtask
endmodule // smr_host

// file: dv/smr_mode_regs_tb.sv
`timescale 1ns/1ps
`include "smr_regs.svh"
module smr_mode_regs_tb
  import smr_pkg::*;
;
  logic       clk = 1'b0, srst = 1'b1, init_complete = 1'b0, cal_init_done = 1'b0;
  logic       cal_cmd_req = 1'b0, burst_req = 1'b0, burst_write = 1'b0, burst_ap = 1'b0;
  logic [1:0] cal_test_code = 2'h0, c2;
  smr_col_t   burst_start = 10'h000, beat_col;
  logic       mrw_valid, mrr_valid, mrr_data_valid, cal_cmd_grant, factory_trim;
  logic       burst_ready, burst_illegal, beat_valid, precharge_start;
  logic [7:0] mr_addr, mr_wdata, mrr_data, feat = `SMR_FEAT_RESET;
  logic [7:0] fw[9] = '{8'h23, 8'h2B, 8'h21, 8'h32, 8'h3A, 8'h33, 8'h34, 8'hE2, 8'h22};
  logic [9:0] q_rd[$], q_col[$], q_pre[$];
  int         miscompares = 0, compares = 0, cyc = 0, last = 0;
  // ========================================================================
  // Clock, host and design
  always #12.5 clk = ~clk;
  smr_host host (.clk(clk), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid),
    .mr_addr(mr_addr), .mr_wdata(mr_wdata));
  smr_mode_regs DUT (.clk(clk), .srst(srst), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid),
    .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mrr_data(mrr_data),
    .mrr_data_valid(mrr_data_valid), .init_complete(init_complete),
    .cal_init_done(cal_init_done), .cal_test_code(cal_test_code),
    .cal_cmd_req(cal_cmd_req), .cal_cmd_grant(cal_cmd_grant), .factory_trim(factory_trim),
    .burst_req(burst_req), .burst_write(burst_write), .burst_ap(burst_ap),
    .burst_start(burst_start), .burst_ready(burst_ready), .burst_illegal(burst_illegal),
    .beat_col(beat_col), .beat_valid(beat_valid), .precharge_start(precharge_start));
  // ========================================================================
  // Compare and report
  task automatic fail(input string m);
    $display("CHECK FAILED %0t %s", $time, m);
    miscompares++;
  endtask
  task automatic chk_f(input logic got, input logic exp);
    compares++;
    if (got !== exp)
      fail("flag mismatch");
  endtask
  task automatic chk_v(ref logic [9:0] q[$], input logic [9:0] got, input string m);
    compares++;
    if (q.size() == 0)
      fail(m);
    else if (q.pop_front() !== got)
      fail(m);
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ========================================================================
  // Stimulus helpers
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back({2'h0, e});
    host.cmd(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] d);
    host.cmd(1'b1, `SMR_ADDR_FEATURE, d);
    if (d[2:0] inside {[3'h2:3'h4]} && d[7:5] inside {[3'h1:3'h6]})
      feat = d;
  endtask
  task automatic cal(input logic [1:0] c);
    @(posedge clk);
    #2;
    {cal_test_code, cal_init_done} = {c, 1'b1};
    @(posedge clk);
    #2;
    {cal_test_code, cal_init_done} = {~c, 1'b0};
  endtask
  function automatic smr_col_t exp_col(input smr_col_t s, input logic [2:0] i);
    smr_col_t b;
    b = {s[9:1], 1'b0};
    if (feat[4])
      return b + 10'(i);
    if (feat[2:0] == `SMR_BL4)
      return {b[9:2], b[1:0] + i[1:0]};
    if (feat[3])
      return {b[9:3], b[2:0] ^ i};
    return {b[9:3], b[2:0] + i};
  endfunction
  task automatic burst(input smr_col_t s, input logic w, input logic ap);
    logic ok;
    int   k;
    k = 0;
    @(posedge clk);
    #2;
    while (burst_ready !== 1'b1 && k < 60)
    begin
      @(posedge clk);
      #2;
      k++;
    end
    ok = feat[2:0] != `SMR_BL16 && !(feat[4] && feat[2:0] == `SMR_BL8);
    for (int i = 0; ok && i < (feat[2:0] == `SMR_BL8 ? 8 : 4); i++)
      q_col.push_back(exp_col(s, 3'(i)));
    if (ok && w && ap)
      q_pre.push_back(10'(feat[7:5]) + 10'h2);
    {burst_req, burst_write, burst_ap, burst_start} = {1'b1, w, ap, s};
    #1;
    chk_f(burst_illegal, !ok);
    @(posedge clk);
    #2;
    {burst_req, burst_start} = {1'b0, ~s};
    // Let the beats and any recovery finish before the feature word may change
    while (burst_ready !== 1'b1)
    begin
      @(posedge clk);
      #2;
    end
  endtask
  // ========================================================================
  // Result watcher
  always @(posedge clk)
  begin
    cyc++;
    if (mrr_data_valid === 1'b1)
      chk_v(q_rd, {2'h0, mrr_data}, "read data");
    if (beat_valid === 1'b1)
      last = cyc;
    if (beat_valid === 1'b1)
      chk_v(q_col, beat_col, "beat column");
    if (precharge_start === 1'b1)
      chk_v(q_pre, 10'(cyc - last), "precharge delay");
    if (cyc > 6000)
    begin
      fail("timeout");
      give_verdict();
    end
  end
  // ========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hFE98));
    repeat (10) @(posedge clk);
    #2;
    srst = 1'b0;
    chk_f(burst_ready, 1'b1);
    chk_f(factory_trim, 1'b0);
    rd(`SMR_ADDR_INFO, 8'h01);
    @(posedge clk);
    #2;
    init_complete = 1'b1;
    @(posedge clk);
    #2;
    {init_complete, cal_test_code} = {1'b0, `SMR_CAL_OK};
    rd(`SMR_ADDR_INFO, 8'h00);
    cal(`SMR_CAL_OK);
    rd(`SMR_ADDR_INFO, 8'h18);
    cal_cmd_req = 1'b1;
    #1;
    chk_f(cal_cmd_grant, 1'b1);
    host.cmd(1'b1, `SMR_ADDR_INFO, 8'hFF);
    rd(`SMR_ADDR_INFO, 8'h18);
    rd(8'h05, 8'h00);
    burst(10'($urandom), 1'b0, 1'b0);
    // Legal, reserved and refused feature words in turn
    foreach (fw[i])
    begin
      wr(fw[i]);
      burst(10'($urandom), 1'($urandom), 1'b0);
    end
    for (int t = 51; t < 200; t += 25)
    begin
      wr({host.wr_code(t), 5'h02});
      burst(10'($urandom), 1'b1, 1'b1);
    end
    c2 = 2'h1 + 2'($urandom % 2);
    cal(c2);
    rd(`SMR_ADDR_INFO, {3'h0, c2, 3'h0});
    chk_f(factory_trim, 1'b1);
    chk_f(cal_cmd_grant, 1'b0);
    repeat (20) @(posedge clk);
    chk_f(q_rd.size() + q_col.size() + q_pre.size() == 0, 1'b1);
    give_verdict();
  end
endmodule // smr_mode_regs_tb
